// [rtl/tsip_irq_ctrl.sv]
`timescale 1ns/1ps
`include "tsip_consts.svh"
module tsip_irq_ctrl
  import tsip_pkg::*;
(
  input wire logic core_clk, // Machine-cycle clock
  input wire logic rst, // Async reset, active high
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  output logic [7:0] sfr_rdata, // Read data, registered
  input wire logic ext0_request, // External 0 flag
  input wire logic tmr0_overflow_request, // Timer 0 flag
  input wire logic ext1_request, // External 1 flag
  input wire logic tmr1_overflow_request, // Timer 1 flag
  input wire logic serial_receive_request, // Serial receive flag
  input wire logic serial_transmit_request, // Serial transmit flag
  input wire logic tmr2_overflow_request, // Timer 2 overflow flag
  input wire logic adc_done_request, // ADC flag
  input wire logic [6:2] ext_set, // Set pulses for ext2..ext6 flags
  input wire logic tmr2_reload_pin, // Timer 2 reload input pin
  input wire logic watchdog_status_bit, // Watchdog status
  input wire logic poll_ok, // CPU may take a call this cycle
  input wire logic reti, // Return from interrupt pulse
  output logic irq_call, // Vector call pulse
  output logic [15:0] irq_vector, // Vector address
  output logic [6:2] ext_request, // ext2..ext6 request flags
  output logic tmr2_reload_request, // Timer 2 reload flag
  output logic watchdog_refresh, // Watchdog refresh pulse
  output logic watchdog_start, // Watchdog start pulse
  output logic [3:0] active_levels // Levels in progress
);
  logic [7:0] en_a_r, en_a_nxt, en_b_r, en_b_nxt, pl_r, pl_nxt, ph_r, ph_nxt;
  logic [7:0] rdata_nxt;
  logic [6:2] ext_r, ext_nxt;
  logic reload_r, reload_nxt, pin_d_r;
  logic wd_ref_nxt, wd_st_nxt;
  logic call_nxt;
  logic [15:0] vec_nxt;
  logic [3:0] act_r, act_nxt;
  logic [11:0] req;
  logic found;
  logic [3:0] win_idx;
  tsip_level_type win_level;
  logic wr_a, wr_b, wr_pl, wr_ph;
  logic take, cfg_wr;
  logic [3:0] pop;

  assign wr_a = sfr_wr && sfr_addr == `TSIP_ADDR_ENABLE_A;
  assign wr_b = sfr_wr && sfr_addr == `TSIP_ADDR_ENABLE_B;
  assign wr_pl = sfr_wr && sfr_addr == `TSIP_ADDR_PRIO_LOW;
  assign wr_ph = sfr_wr && sfr_addr == `TSIP_ADDR_PRIO_HIGH;

  // Gated requests, index = pair for left members, pair + 6 for right members
  always_comb begin
    logic [11:0] raw;
    logic [11:0] en;
    raw = {ext_r[6], ext_r[5], ext_r[4], ext_r[3], ext_r[2], adc_done_request,
           tmr2_overflow_request | reload_r,
           serial_receive_request | serial_transmit_request,
           tmr1_overflow_request, ext1_request, tmr0_overflow_request, ext0_request};
    en = {en_b_r[5:0], en_a_r[5:0]};
    req = en_a_r[`TSIP_BIT_GLOBAL_EN] ? (raw & en) : 12'h000;
  end

  tsip_arbiter #(.NSRC(`TSIP_NUM_SRC)) u_arb (
    .req(req),
    .prio_low(pl_r[5:0]),
    .prio_high(ph_r[5:0]),
    .active(act_r),
    .found(found),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  // Calls are refused right after a call, on return and on register writes
  assign cfg_wr = wr_a || wr_b || wr_pl || wr_ph;
  assign take = found && poll_ok && !irq_call && !reti && !cfg_wr;

  // Left members count up from one base, right members from the other
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    if (idx < 4'h6) begin
      return `TSIP_VEC_BASE_A + `TSIP_VEC_STEP * {12'h000, idx};
    end
    return `TSIP_VEC_BASE_B + `TSIP_VEC_STEP * ({12'h000, idx} - 16'h0006);
  endfunction

  // Enable and priority registers; watchdog bits only pulse
  always_comb begin
    en_a_nxt = en_a_r;
    en_b_nxt = en_b_r;
    pl_nxt = pl_r;
    ph_nxt = ph_r;
    wd_ref_nxt = 1'b0;
    wd_st_nxt = 1'b0;
    if (wr_a) begin
      en_a_nxt = sfr_wdata & ~(8'h01 << `TSIP_BIT_WDT_REFRESH);
      wd_ref_nxt = sfr_wdata[`TSIP_BIT_WDT_REFRESH];
    end
    if (wr_b) begin
      en_b_nxt = sfr_wdata & ~(8'h01 << `TSIP_BIT_WDT_START);
      wd_st_nxt = sfr_wdata[`TSIP_BIT_WDT_START];
    end
    if (wr_pl) begin
      pl_nxt = sfr_wdata & `TSIP_PAIR_MASK;
    end
    if (wr_ph) begin
      ph_nxt = sfr_wdata & `TSIP_PAIR_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_a_r <= `TSIP_ENABLE_A_RST;
      en_b_r <= `TSIP_ENABLE_B_RST;
      pl_r <= `TSIP_PRIO_RST;
      ph_r <= `TSIP_PRIO_RST;
      watchdog_refresh <= 1'b0;
      watchdog_start <= 1'b0;
    end else begin
      en_a_r <= en_a_nxt;
      en_b_r <= en_b_nxt;
      pl_r <= pl_nxt;
      ph_r <= ph_nxt;
      watchdog_refresh <= wd_ref_nxt;
      watchdog_start <= wd_st_nxt;
    end
  end

  // Request flags held here; a new set beats the vectoring clear
  always_comb begin
    reload_nxt = reload_r;
    if (pin_d_r && !tmr2_reload_pin && en_b_r[`TSIP_BIT_RELOAD_EN]) begin
      reload_nxt = 1'b1;
    end
    ext_nxt = ext_r;
    if (take && win_idx >= 4'h7) begin
      ext_nxt[win_idx - 4'h5] = 1'b0;
    end
    ext_nxt = ext_nxt | ext_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_r <= 5'h00;
      reload_r <= 1'b0;
      pin_d_r <= 1'b1;
    end else begin
      ext_r <= ext_nxt;
      reload_r <= reload_nxt;
      pin_d_r <= tmr2_reload_pin;
    end
  end

  // Vector call pulse; the address holds until the next call
  always_comb begin
    call_nxt = take;
    vec_nxt = irq_vector;
    if (take) begin
      vec_nxt = vector_of(win_idx);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_call <= 1'b0;
      irq_vector <= 16'h0000;
    end else begin
      irq_call <= call_nxt;
      irq_vector <= vec_nxt;
    end
  end

  // Return drops the highest level in progress, a call marks its own
  always_comb begin
    pop = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (act_r[i]) begin
        pop = 4'h1 << i;
      end
    end
    act_nxt = act_r;
    if (reti) begin
      act_nxt = act_nxt & ~pop;
    end
    if (take) begin
      act_nxt[win_level] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_r <= 4'h0;
    end else begin
      act_r <= act_nxt;
    end
  end

  // Read data stands one cycle; idle and unmapped reads give zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `TSIP_ADDR_ENABLE_A: rdata_nxt = en_a_r;
        `TSIP_ADDR_ENABLE_B: rdata_nxt = en_b_r;
        `TSIP_ADDR_PRIO_LOW: begin
          rdata_nxt = pl_r;
          rdata_nxt[`TSIP_BIT_WDT_STATUS] = watchdog_status_bit;
        end
        `TSIP_ADDR_PRIO_HIGH: rdata_nxt = ph_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_nxt;
    end
  end

  assign ext_request = ext_r;
  assign tmr2_reload_request = reload_r;
  assign active_levels = act_r;
endmodule // tsip_irq_ctrl

// [rtl/tsip_consts.svh]
`ifndef TSIP_CONSTS_SVH
`define TSIP_CONSTS_SVH
`define TSIP_ADDR_ENABLE_A 8'ha8
`define TSIP_ADDR_PRIO_LOW 8'ha9
`define TSIP_ADDR_ENABLE_B 8'hb8
`define TSIP_ADDR_PRIO_HIGH 8'hb9
`define TSIP_BIT_GLOBAL_EN 7
`define TSIP_BIT_WDT_REFRESH 6
`define TSIP_BIT_WDT_START 6
`define TSIP_BIT_RELOAD_EN 7
`define TSIP_BIT_WDT_STATUS 6
`define TSIP_PAIR_MASK 8'h3f
`define TSIP_ENABLE_A_RST 8'h00
`define TSIP_ENABLE_B_RST 8'h00
`define TSIP_PRIO_RST 8'h00
`define TSIP_VEC_BASE_A 16'h0003
`define TSIP_VEC_BASE_B 16'h0043
`define TSIP_VEC_STEP 16'h0008
`define TSIP_NUM_SRC 12
`endif

// [rtl/tsip_pkg.sv]
package tsip_pkg;
  typedef logic [1:0] tsip_level_type;
  typedef enum logic [1:0] {TSIP_IDLE, TSIP_CALL} tsip_state_type;
endpackage

// [rtl/tsip_arbiter.sv]
`timescale 1ns/1ps
`include "tsip_consts.svh"
// Picks the winning source: highest level, then fixed polling order
module tsip_arbiter
  import tsip_pkg::*;
#(
  parameter int NSRC = 12
) (
  input wire logic [NSRC-1:0] req, // Enabled pending requests
  input wire logic [5:0] prio_low, // Low level bit per pair
  input wire logic [5:0] prio_high, // High level bit per pair
  input wire logic [3:0] active, // Levels in progress
  output logic found, // A source may be taken
  output logic [3:0] win_idx, // Winning source index
  output tsip_level_type win_level // Level of the winner
);
  // Source s: s<6 is left member of pair s, else right member of pair s-6
  function automatic tsip_level_type level_of(input int s);
    int p;
    p = (s < 6) ? s : s - 6;
    level_of = {prio_high[p], prio_low[p]};
  endfunction

  always_comb begin
    int lv;
    int pr;
    int s;
    lv = 0;
    pr = 0;
    s = 0;
    found = 1'b0;
    win_idx = 4'h0;
    win_level = 2'h0;
    // Highest level first, then pair order, left before right
    for (lv = 3; lv >= 0; lv--) begin
      for (pr = 0; pr < 12; pr++) begin
        if (!found && pr < NSRC) begin
          s = (pr % 2 == 0) ? pr / 2 : pr / 2 + 6;
          // Only a strictly higher level than any active one may enter
          if (req[s] && level_of(s) == lv[1:0] && (active >> lv) == 4'h0) begin
            found = 1'b1;
            win_idx = s[3:0];
            win_level = lv[1:0];
          end
        end
      end
    end
  end
endmodule // tsip_arbiter

// [verif/tsip_irq_ctrl_monitor.sv]
`timescale 1ns/1ps
module tsip_irq_ctrl_monitor (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] sfr_addr, // Address
  input wire logic [7:0] sfr_wdata, // Data
  input wire logic sfr_wr, // Write
  input wire logic sfr_rd, // Read
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic watchdog_status_bit, // Status
  input wire logic poll_ok, // Poll
  input wire logic reti, // Return
  input wire logic irq_call, // Call
  input wire logic [15:0] irq_vector, // Vector
  input wire logic [6:2] ext_request, // Flags
  input wire logic [6:2] ext_set, // Flag set pulses
  input wire logic watchdog_refresh, // Pulse
  input wire logic watchdog_start, // Start pulse
  input wire logic [3:0] active_levels // Levels
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_gap; irq_call |=> !irq_call; endproperty
  a_gap: assert property (p_gap) else $error("call too long");
  property p_why;
    irq_call |-> $past(poll_ok) && !$past(reti) && !$past(sfr_wr && (sfr_addr == 8'ha8
      || sfr_addr == 8'ha9 || sfr_addr == 8'hb8 || sfr_addr == 8'hb9));
  endproperty
  a_why: assert property (p_why) else $error("call blocked");
  property p_top; irq_call |-> !$past(active_levels[3]); endproperty
  a_top: assert property (p_top) else $error("level 3 preempted");
  property p_push; irq_call |-> active_levels > $past(active_levels); endproperty
  a_push: assert property (p_push) else $error("level not raised");
  property p_pop; reti && active_levels != 4'h0 |=> active_levels < $past(active_levels);
  endproperty
  a_pop: assert property (p_pop) else $error("return kept level");
  property p_clr; irq_call && irq_vector == 16'h004b |-> $past(ext_request[2]); endproperty
  a_clr: assert property (p_clr) else $error("vector without flag");
  property p_wdr; sfr_wr && sfr_addr == 8'ha8 && sfr_wdata[6] |=> watchdog_refresh;
  endproperty
  a_wdr: assert property (p_wdr) else $error("no refresh pulse");
  property p_sts; sfr_rd && sfr_addr == 8'ha9 |=> sfr_rdata[6] == $past(watchdog_status_bit);
  endproperty
  a_sts: assert property (p_sts) else $error("status bit wrong");
  property p_flag; irq_call && irq_vector == 16'h004b && !$past(ext_set[2]) |-> !ext_request[2];
  endproperty
  a_flag: assert property (p_flag) else $error("flag kept after call");
  property p_wst; sfr_wr && sfr_addr == 8'hb8 && sfr_wdata[6] |=> watchdog_start;
  endproperty
  a_wst: assert property (p_wst) else $error("no start pulse");
  c_call: cover property (irq_call);
  c_pop: cover property (reti && active_levels != 4'h0);
  c_wdr: cover property (watchdog_refresh);
  c_nest: cover property (irq_call && $past(active_levels) != 4'h0);
endmodule // tsip_irq_ctrl_monitor
bind tsip_irq_ctrl tsip_irq_ctrl_monitor tsip_irq_ctrl_monitor_i (.core_clk, .rst, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .watchdog_status_bit, .poll_ok, .reti, .irq_call,
  .irq_vector, .ext_request, .ext_set, .watchdog_refresh, .watchdog_start, .active_levels);

// [verif/tsip_cpu_model.sv]
`timescale 1ns/1ps
module tsip_cpu_model (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic run, // Let calls in
  input wire logic ret_req, // End routine
  input wire logic irq_call, // Call taken
  output logic poll_ok, // Final cycle
  output logic reti // Return pulse
);
  logic poll_nxt;
  // Call occupies the cycle after it
  always_comb poll_nxt = run && !irq_call;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) {poll_ok, reti} <= 2'b00;
    else {poll_ok, reti} <= {poll_nxt, ret_req};
endmodule // tsip_cpu_model

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst = 1, wr, rd, run, rq, pin, wds, call, rlq, pok, reti;
  logic [7:0] ad, wd, lv, rdata, ra, rb, rl, rh;
  logic [6:2] es, eq, ex;
  logic [15:0] vec, v;
  logic [17:0] e;
  logic [3:0] act;
  logic [1:0] l1;
  logic [15:0] v1;
  logic [31:0] seed = 32'h5b57;
  int err_total = 0, comparisons = 0;
  tsip_irq_ctrl tsip_irq_ctrl_i (.core_clk, .rst, .sfr_addr(ad), .sfr_wdata(wd), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_rdata(rdata), .ext0_request(lv[0]), .tmr0_overflow_request(lv[1]),
    .ext1_request(lv[2]), .tmr1_overflow_request(lv[3]), .serial_receive_request(lv[4]),
    .serial_transmit_request(lv[7]), .tmr2_overflow_request(lv[5]), .adc_done_request(lv[6]),
    .ext_set(es), .tmr2_reload_pin(pin), .watchdog_status_bit(wds), .poll_ok(pok), .reti,
    .irq_call(call), .irq_vector(vec), .ext_request(eq), .tmr2_reload_request(rlq),
    .watchdog_refresh(), .watchdog_start(), .active_levels(act));
  tsip_cpu_model tsip_cpu_model_i (.core_clk, .rst, .run, .ret_req(rq), .irq_call(call),
    .poll_ok(pok), .reti);
  initial forever #5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [17:0] expv(input logic [6:2] x);
    logic [5:0] l, r;
    logic [17:0] w;
    l = ra[5:0] & {lv[5] | rb[7], lv[4] | lv[7], lv[3:0]};
    r = rb[5:0] & {x, lv[6]};
    w = '0;
    for (int p = 5; p >= 0; p--)
      for (int s = 1; s >= 0; s--)
        if (ra[7] && (s ? r[p] : l[p]) && (w[15:0] == 0 || {rh[p], rl[p]} >= w[17:16]))
          w = {rh[p], rl[p], (s ? 16'h0043 : 16'h0003) + 16'(8 * p)};
    return w;
  endfunction
  task automatic chk(input string n, input logic [15:0] x, g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [7:0] x, g);
    chk(n, {8'h00, x}, {8'h00, g});
  endtask
  task automatic chk_mask(input string n, input logic [7:0] x, g);
    chk(n, {8'h00, x}, {8'h00, g});
  endtask
  task automatic cyc;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, d);
    cyc;
    {ad, wd, wr} = {a, d, 1'b1};
    cyc;
    wr = 0;
  endtask
  task automatic regs;
    logic [7:0] ev [5];
    logic [7:0] am [5];
    ev = '{ra & 8'hbf, {1'b0, wds, rl[5:0]}, rb & 8'hbf, {2'b00, rh[5:0]}, 8'h00};
    am = '{8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'h5a};
    for (int k = 0; k < 5; k++) begin
      cyc;
      {ad, rd} = {am[k], 1'b1};
      cyc;
      rd = 0;
      chk_reg("register", ev[k], rdata);
    end
  endtask
  task automatic wcall(output logic [15:0] g);
    g = '0;
    for (int k = 0; k < 12 && g == 0; k++) begin
      cyc;
      if (call === 1'b1) g = vec;
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {wr, rd, run, rq, wds, ad, wd, lv, es} = '0;
    pin = 1;
    repeat (4) cyc;
    for (int i = 0; i < 40; i++) begin
      repeat (6) seed = lfsr(seed);
      {run, lv, ra, rb, rl, rh, pin, rst, wds} = {41'h0, 2'b11, seed[9]};
      cyc;
      cyc;
      rst = 0;
      regs;
      {ra, rb, rl, rh} = (i == 0) ? 32'hbf3fffff : seed;
      if (i == 1) ra = 8'h3f;
      wreg(8'ha8, ra);
      wreg(8'hb8, rb);
      wreg(8'ha9, rl);
      wreg(8'hb9, rh);
      {lv, ex} = (i == 0) ? 13'h1fff : seed[20:8];
      {es, pin} = {ex, 1'b0};
      cyc;
      es = 0;
      regs;
      chk_mask("reload", {7'h0, rb[7]}, {7'h0, rlq});
      e = expv(ex);
      run = 1;
      wcall(v);
      chk("vector", e[15:0], v);
      {l1, v1} = {e[17:16], v};
      chk_mask("levels", (v != 0) ? 8'(1 << e[17:16]) : 8'h0, {4'h0, act});
      if (v > 16'h0043) ex[((v - 16'h0043) >> 3) + 1] = 1'b0;
      chk_mask("flags", {3'h0, ex}, {3'h0, eq});
      wcall(v);
      chk("nested", 16'h0, v);
      // Raise every pair to the top level with calls held off
      run = 0;
      {rl, rh} = 16'hffff;
      wreg(8'ha9, rl);
      wreg(8'hb9, rh);
      run = 1;
      e = expv(ex);
      wcall(v);
      chk("preempt", (v1 != 0 && l1 == 2'h3) ? 16'h0 : e[15:0], v);
      if (v > 16'h0043) ex[((v - 16'h0043) >> 3) + 1] = 1'b0;
      rq = 1;
      cyc;
      rq = 0;
      e = expv(ex);
      wcall(v);
      chk("after return", e[15:0], v);
    end
    complete_run;
  end
  initial begin
    #100us;
    err_total++;
    complete_run;
  end
endmodule // testbench
